// ### cgrd_pkg.sv
// How it works
// - available charge is high byte at 03h (rw) plus low byte at 17h (ro)
// - at reset charge is zero, or high byte takes programmed capacity if fill pin high
// - a valid charge clears the low byte of the available charge
// - pack type register at 04h is plain storage with no effect on gauging
// - learned capacity at 05h is written, learned, and reset to programmed capacity
// - fast-charge flag sets when charging starts, clears below two counts per second
// - fast-charge flag selects fast or trickle charge efficiency
// - discharge rate code in bits 6-4, 001 when sense below -150 mV
// - overload flag set below -250 mV, cleared half a second after it ends
// - end-of-discharge sampling resumes half a second after overload ends
// - register 07h shows pull-down detected per segment pin, bits 0 to 5
// - register 08h shows pull-up detected per segment pin, bits 0 to 5
// - charge-cycle tally at 09h counts valid charges, saturating at 255
// - above 0.94 of capacity only the first valid charge counts
// - unreliable flag sets when tally reaches 64; capacity learning clears both
// - capacity learns only after clean full-to-empty discharge, warm, low self-discharge
// - magnitude filter register at 0ah is read/write storage only; no logic here uses it
// - reset loads capacity, clears tally, discharge flag, charge; sets two flags
// - relative mode five segments per 20% learned; absolute 20% programmed plus overfull
// - enable pin high off, floating on while counting fast, low always on
// - segments alternate odd and even banks each 100 Hz period, lit for 30% of that period
// - first segment blinks 4 Hz on first empty warning; final warning blanks all
package cgrd_pkg;
    localparam logic [7:0] ADDR_ACH  = 8'h03;
    localparam logic [7:0] ADDR_PACK = 8'h04;
    localparam logic [7:0] ADDR_LFC  = 8'h05;
    localparam logic [7:0] ADDR_SF   = 8'h06;
    localparam logic [7:0] ADDR_PD   = 8'h07;
    localparam logic [7:0] ADDR_PU   = 8'h08;
    localparam logic [7:0] ADDR_TALLY = 8'h09;
    localparam logic [7:0] ADDR_MAG  = 8'h0a;
    localparam logic [7:0] ADDR_ACL  = 8'h17;
    localparam logic [7:0] ADDR_RST  = 8'h39;
    localparam logic [7:0] RST_KEY   = 8'h80;
    localparam logic [7:0] MAG_RESET = 8'h00;
    localparam int  CLK_HZ        = 125000000;
    localparam int  OVERLOAD_FLAG_HOLD_MS  = 500;
    localparam int  OVERLOAD_FLAG_HOLD_CYC = CLK_HZ / 1000 * OVERLOAD_FLAG_HOLD_MS;
    localparam int  SLOW_WIN_MS   = 500;   // one count per half second = 2/s
    localparam int  SLOW_WIN_CYC  = CLK_HZ / 1000 * SLOW_WIN_MS;
    localparam int  MUX_HZ        = 100;
    localparam int  MUX_CYC       = CLK_HZ / MUX_HZ;
    localparam int  BANK_ON_CYC   = MUX_CYC * 30 / 100;
    localparam int  BLINK_HZ      = 4;
    localparam int  BLINK_HALF_CYC = CLK_HZ / BLINK_HZ / 2;
    localparam logic [7:0] TALLY_MAX  = 8'hff;
    localparam logic [7:0] TALLY_WARN = 8'h40;
    localparam int  SDC_LIMIT     = 4096;
    localparam logic [2:0] DR_LIGHT = 3'h0;
    localparam logic [2:0] DR_HEAVY = 3'h1;
    typedef enum logic [1:0] {CGRD_EN_OFF, CGRD_EN_FLOAT, CGRD_EN_ON} cgrd_en_t;
    typedef struct packed {
        logic       valid_charge;  // one-cycle event
        logic       charge_up;     // charge count step
        logic       charge_dn;     // discharge / self-discharge step
        logic       heavy_dis;     // sense below -150 mV
        logic       overload;      // sense below -250 mV
        logic       fast_count;    // counting at >= 4 mV equivalent
        logic       first_empty;
        logic       final_empty;
        logic       cold;          // temperature below 0 C
        logic [12:0] self_dis_cnt;
    } cgrd_meas_t;
endpackage

// ### cgrd_display.sv
`timescale 1ns/100ps
module cgrd_display
    import cgrd_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_active,
    input  wire logic        i_blink_one,
    input  wire logic [5:0]  i_level,
    output logic [5:0]       o_seg
);
    logic [20:0] mux_cnt;
    logic [24:0] blink_cnt;
    logic        blink_ph;
    logic        bank_odd;

    // mux period counter, bank toggles each period
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mux_cnt  <= '0;
            bank_odd <= 1'b1;
        end else if (mux_cnt == 21'(MUX_CYC - 1)) begin
            mux_cnt  <= '0;
            bank_odd <= ~bank_odd;
        end else begin
            mux_cnt <= mux_cnt + 21'h1;
        end
    end

    // 4 hz blink phase
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            blink_cnt <= '0;
            blink_ph  <= 1'b0;
        end else if (blink_cnt == 25'(BLINK_HALF_CYC - 1)) begin
            blink_cnt <= '0;
            blink_ph  <= ~blink_ph;
        end else begin
            blink_cnt <= blink_cnt + 25'h1;
        end
    end

    // odd bank = segments 1,3,5 (bits 0,2,4), on 30% of every other period
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_seg <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                o_seg[i] <= i_active && i_level[i]
                         && (mux_cnt < 21'(BANK_ON_CYC))
                         && (bank_odd == (i % 2 == 0))
                         && !(i == 0 && i_blink_one && blink_ph);
            end
        end
    end
endmodule

// ### cgrd_top.sv
`timescale 1ns/100ps
module cgrd_top
    import cgrd_pkg::*;
#(
    parameter int OVERLOAD_FLAG_CYC = OVERLOAD_FLAG_HOLD_CYC,
    parameter int SLOW_CYC = SLOW_WIN_CYC
)(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_wr,          // host write strobe
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic [7:0]       o_rdata,
    input  wire logic        i_fill_high,   // initial_fill_pin level (pin)
    input  wire logic        i_abs_mode,    // display absolute mode (pin)
    input  wire cgrd_en_t    i_indicator_en,
    input  wire logic [5:0]  i_pd_pins,     // pull-down seen per segment pin
    input  wire logic [5:0]  i_pu_pins,     // pull-up seen per segment pin
    input  wire logic [7:0]  i_prog_full,   // programmed_full_capacity
    input  wire cgrd_meas_t  i_meas,
    output logic [5:0]       o_seg,
    output logic             o_fast_eff,    // fast efficiency selected
    output logic             o_eod_sample,  // end-of-discharge sampling on
    output logic             o_unreliable_full_flag,
    output logic             o_battery_replaced_flag,
    output logic             o_valid_discharge_flag
);
    logic [7:0]  available_charge_high;
    logic [7:0]  available_charge_low;
    logic [7:0]  pack_type_tag;
    logic [7:0]  learned_full_capacity;
    logic [7:0]  charge_cycle_tally;
    logic [7:0]  magnitude_filter_setting;
    logic [7:0]  pulldown_detect;
    logic [7:0]  pullup_detect;
    logic        fast_charge_flag;
    logic [2:0]  discharge_rate_code;
    logic        overload_flag;
    logic [26:0] overload_flag_cnt;
    logic [26:0] slow_cnt;
    logic        tally_blocked;
    logic        soft_rst;
    logic [7:0]  rst_last;
    logic [1:0]  fill_s;
    logic [1:0]  abs_s;
    logic [3:0]  en_s;
    logic [11:0] pd_s;
    logic [11:0] pu_s;
    logic        greset;
    logic [15:0] available_charge_count;
    logic [15:0] lfc_full;
    logic        above_94;
    logic        learn;
    logic        was_full;
    logic [7:0]  dis_count;
    logic [5:0]  level;
    logic        indicator_enable_pin_active;
    logic [7:0]  next_tally;

    // strap sync runs through reset so its level is settled at release
    always_ff @(posedge i_clk) begin
        fill_s <= {fill_s[0], i_fill_high};
    end

    // pin synchronisers, two stages before any logic
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            abs_s  <= '0;
            en_s   <= '0;
            pd_s   <= '0;
            pu_s   <= '0;
        end else begin
            abs_s  <= {abs_s[0], i_abs_mode};
            en_s   <= {en_s[1:0], i_indicator_en};
            pd_s   <= {pd_s[5:0], i_pd_pins};
            pu_s   <= {pu_s[5:0], i_pu_pins};
        end
    end

    assign greset   = !i_rstn || soft_rst;
    assign available_charge_count      = {available_charge_high, available_charge_low};
    assign lfc_full = {learned_full_capacity, 8'h00};
    // 0.94 threshold compared exactly in integers: count*100 > lfc_full*94
    assign above_94 = 32'(available_charge_count) * 32'd100 > 32'(lfc_full) * 32'd94;
    assign learn    = i_meas.first_empty && o_valid_discharge_flag
                   && !i_meas.cold
                   && (i_meas.self_dis_cnt < 13'(SDC_LIMIT));

    // soft reset detects the 00h -> 80h write sequence
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rst_last <= 8'h00;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (i_wr && i_addr == ADDR_RST) begin
                rst_last <= i_wdata;
                soft_rst <= (rst_last == 8'h00) && (i_wdata == RST_KEY);
            end
        end
    end

    // available charge counters; fill strap caught after release
    always_ff @(posedge i_clk) begin
        if (greset) begin
            available_charge_high <= 8'h00;
            available_charge_low  <= 8'h00;
        end else if (was_full == 1'b0 && dis_count == 8'h01) begin
            // first cycle after reset release picks up the fill strap
            available_charge_high <= fill_s[1] ? i_prog_full : 8'h00;
            available_charge_low  <= 8'h00;
        end else if (i_wr && i_addr == ADDR_ACH) begin
            available_charge_high <= i_wdata;
        end else if (i_meas.valid_charge) begin
            available_charge_low <= 8'h00;
        end else if (i_meas.charge_up && available_charge_count != 16'hffff) begin
            {available_charge_high, available_charge_low} <= available_charge_count + 16'h1;
        end else if (i_meas.charge_dn && available_charge_count != 16'h0000) begin
            {available_charge_high, available_charge_low} <= available_charge_count - 16'h1;
        end
    end

    // strap capture sequencer: dis_count doubles as post-reset step
    always_ff @(posedge i_clk) begin
        if (greset) begin
            dis_count <= 8'h01;
            was_full  <= 1'b0;
        end else begin
            dis_count <= 8'h00;
            was_full  <= 1'b1;
        end
    end

    // plain storage for the pack type; no default, not reset
    always_ff @(posedge i_clk) begin
        if (i_wr && i_addr == ADDR_PACK) begin
            pack_type_tag <= i_wdata;
        end
    end

    // learned capacity
    always_ff @(posedge i_clk) begin
        if (greset) begin
            learned_full_capacity <= i_prog_full;
        end else if (i_wr && i_addr == ADDR_LFC) begin
            learned_full_capacity <= i_wdata;
        end else if (learn) begin
            // measured discharge from full to the first warning
            learned_full_capacity <= available_charge_high
                                   + learned_full_capacity
                                   - available_charge_high
                                   - 8'h00 + 8'h00 == 8'h00
                                   ? 8'h01 : learned_full_capacity
                                   - available_charge_high;
        end
    end

    // valid discharge qualifier
    always_ff @(posedge i_clk) begin
        if (greset) begin
            o_valid_discharge_flag <= 1'b0;
        end else if (available_charge_count >= lfc_full && i_meas.charge_dn) begin
            o_valid_discharge_flag <= 1'b1;
        end else if (learn || i_meas.valid_charge
                     || (i_meas.first_empty && i_meas.cold)
                     || i_meas.self_dis_cnt >= 13'(SDC_LIMIT)) begin
            o_valid_discharge_flag <= 1'b0;
        end
    end

    // charge-cycle tally and unreliable flag
    always_comb begin
        next_tally = charge_cycle_tally;
        if (i_meas.valid_charge && (!tally_blocked || !above_94)
            && charge_cycle_tally != TALLY_MAX) begin
            next_tally = charge_cycle_tally + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (greset) begin
            charge_cycle_tally      <= 8'h00;
            tally_blocked           <= 1'b0;
            o_unreliable_full_flag  <= 1'b1;
            o_battery_replaced_flag <= 1'b1;
        end else begin
            if (learn) begin
                charge_cycle_tally     <= 8'h00;
                o_unreliable_full_flag <= 1'b0;
            end else begin
                charge_cycle_tally <= next_tally;
                if (next_tally == TALLY_WARN
                    && charge_cycle_tally != TALLY_WARN) begin
                    o_unreliable_full_flag <= 1'b1;
                end
            end
            // above 94%, one counted charge then hold until below
            if (!above_94) begin
                tally_blocked <= 1'b0;
            end else if (i_meas.valid_charge) begin
                tally_blocked <= 1'b1;
            end
            if (available_charge_count >= lfc_full || i_meas.first_empty) begin
                o_battery_replaced_flag <= 1'b0;
            end
        end
    end

    // fast-charge flag: a charge step resets the slow window
    always_ff @(posedge i_clk) begin
        if (greset) begin
            fast_charge_flag <= 1'b0;
            slow_cnt         <= '0;
        end else if (i_meas.charge_up) begin
            fast_charge_flag <= 1'b1;
            slow_cnt         <= '0;
        end else if (slow_cnt == 27'(SLOW_CYC - 1)) begin
            fast_charge_flag <= 1'b0;
        end else begin
            slow_cnt <= slow_cnt + 27'h1;
        end
    end

    // overload flag with half-second release hold
    always_ff @(posedge i_clk) begin
        if (greset) begin
            overload_flag       <= 1'b0;
            overload_flag_cnt            <= '0;
            discharge_rate_code <= DR_LIGHT;
        end else begin
            discharge_rate_code <= i_meas.heavy_dis ? DR_HEAVY : DR_LIGHT;
            if (i_meas.overload) begin
                overload_flag <= 1'b1;
                overload_flag_cnt      <= '0;
            end else if (overload_flag) begin
                if (overload_flag_cnt == 27'(OVERLOAD_FLAG_CYC - 1)) begin
                    overload_flag <= 1'b0;
                end else begin
                    overload_flag_cnt <= overload_flag_cnt + 27'h1;
                end
            end
        end
    end

    // registered side outputs and detect registers
    always_ff @(posedge i_clk) begin
        if (greset) begin
            o_fast_eff      <= 1'b0;
            o_eod_sample    <= 1'b1;
            pulldown_detect <= 8'h00;
            pullup_detect   <= 8'h00;
        end else begin
            o_fast_eff      <= fast_charge_flag;
            o_eod_sample    <= !overload_flag;
            pulldown_detect <= {2'b00, pd_s[11:6]};
            pullup_detect   <= {2'b00, pu_s[11:6]};
        end
    end

    // magnitude filter setting; stored and read back only, nothing here reads it
    always_ff @(posedge i_clk) begin
        if (greset) begin
            magnitude_filter_setting <= MAG_RESET;
        end else if (i_wr && i_addr == ADDR_MAG) begin
            magnitude_filter_setting <= i_wdata;
        end
    end

    // read mux; unmapped and write-only read as zero
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            unique case (i_addr)
                ADDR_ACH:   o_rdata <= available_charge_high;
                ADDR_ACL:   o_rdata <= available_charge_low;
                ADDR_PACK:  o_rdata <= pack_type_tag;
                ADDR_LFC:   o_rdata <= learned_full_capacity;
                ADDR_SF:    o_rdata <= {fast_charge_flag, discharge_rate_code,
                                        3'b000, overload_flag};
                ADDR_PD:    o_rdata <= pulldown_detect;
                ADDR_PU:    o_rdata <= pullup_detect;
                ADDR_TALLY: o_rdata <= charge_cycle_tally;
                ADDR_MAG:   o_rdata <= magnitude_filter_setting;
                default:    o_rdata <= 8'h00;
            endcase
        end
    end

    // bar level: fifths of the chosen reference
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            level[i] = abs_s[1]
                ? 32'(available_charge_count) * 32'd5 > 32'(i_prog_full) * 32'd256 * 32'(i)
                : 32'(available_charge_count) * 32'd5 > 32'(lfc_full) * 32'(i);
        end
        level[5] = abs_s[1] && (available_charge_count > {i_prog_full, 8'h00});
    end

    // enable mode decode
    always_comb begin
        unique case (cgrd_en_t'(en_s[3:2]))
            CGRD_EN_OFF:   indicator_enable_pin_active = 1'b0;
            CGRD_EN_FLOAT: indicator_enable_pin_active = i_meas.fast_count;
            CGRD_EN_ON:    indicator_enable_pin_active = 1'b1;
            default:       indicator_enable_pin_active = 1'b0;
        endcase
    end

    cgrd_display i_cgrd_display (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_active    (indicator_enable_pin_active && !i_meas.final_empty),
        .i_blink_one (i_meas.first_empty),
        .i_level     (level),
        .o_seg       (o_seg)
    );

    property p_overload_flag_set;
        @(posedge i_clk) disable iff (greset)
        i_meas.overload |=> overload_flag;
    endproperty
    a_overload_flag_set: assert property (p_overload_flag_set) else $error("overload");

    property p_sample_off;
        @(posedge i_clk) disable iff (greset)
        overload_flag |=> !o_eod_sample;
    endproperty
    a_sample_off: assert property (p_sample_off) else $error("sampling");

    property p_fast_set;
        @(posedge i_clk) disable iff (greset)
        i_meas.charge_up |=> fast_charge_flag ##1 o_fast_eff;
    endproperty
    a_fast_set: assert property (p_fast_set) else $error("fast flag");

    property p_tally_sat;
        @(posedge i_clk) disable iff (greset)
        charge_cycle_tally == TALLY_MAX && !learn |=> charge_cycle_tally == TALLY_MAX;
    endproperty
    a_tally_sat: assert property (p_tally_sat) else $error("tally wrap");

    property p_low_clear;
        @(posedge i_clk) disable iff (greset || dis_count != 8'h00)
        i_meas.valid_charge && !(i_wr && i_addr == ADDR_ACH)
            |=> available_charge_low == 8'h00;
    endproperty
    a_low_clear: assert property (p_low_clear) else $error("low byte");

    property p_learn_clear;
        @(posedge i_clk) disable iff (greset)
        learn |=> charge_cycle_tally == 8'h00 && !o_unreliable_full_flag;
    endproperty
    a_learn_clear: assert property (p_learn_clear) else $error("learn");

    property p_rate_code;
        @(posedge i_clk) disable iff (greset)
        i_meas.heavy_dis |=> discharge_rate_code == DR_HEAVY;
    endproperty
    a_rate_code: assert property (p_rate_code) else $error("rate");

    property p_blank;
        @(posedge i_clk) disable iff (!i_rstn)
        i_meas.final_empty [*2] |=> o_seg == 6'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("blank");

    c_learn: cover property (@(posedge i_clk) learn);
    c_overload_flag:  cover property (@(posedge i_clk) $fell(overload_flag));
    c_soft:  cover property (@(posedge i_clk) soft_rst);
endmodule

// ### cgrd_host.sv
`timescale 1ns/100ps
// host side of the register link, one request per two falling edges
module cgrd_host
    import cgrd_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    // idle bus until the first request
    initial begin
        o_wr    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end

    // strobe lasts one edge so a write is never taken twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr    = 1'b1;
        o_addr  = a;
        o_wdata = d;
        @(negedge i_clk);
        o_wr    = 1'b0;
    endtask

    // read data follows the address by one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        @(negedge i_clk);
        d = i_rdata;
    endtask

    // start from a cleared value and only ever set the top bit
    task automatic soft_reset();
        wr(ADDR_RST, 8'h00);
        wr(ADDR_RST, RST_KEY);
    endtask
endmodule

// ### cgrd_top_tb.sv
`timescale 1ns/100ps
module cgrd_top_tb
    import cgrd_pkg::*;
();
    logic       clk, rstn, fill, absm, wr, fast_eff, eod, unrel, repl, vdis;
    logic [7:0] prog, addr, wdata, rdata, d;
    logic [5:0] pd, pu, seg;
    cgrd_en_t   en;
    cgrd_meas_t meas;
    int         num_errors, num_checks, cyc;
    // write or not, address, data, expected read-back
    logic [24:0] rows [0:10] = '{
        {1'b1, ADDR_PACK, 8'h5a, 8'h5a}, {1'b1, ADDR_LFC, 8'h33, 8'h33},
        {1'b1, ADDR_MAG, 8'h12, 8'h12}, {1'b1, ADDR_ACH, 8'h20, 8'h20},
        {1'b1, ADDR_SF, 8'hff, 8'h00}, {1'b1, ADDR_PD, 8'hff, 8'h09},
        {1'b1, ADDR_PU, 8'hff, 8'h24}, {1'b1, ADDR_TALLY, 8'hff, 8'h00},
        {1'b1, ADDR_ACL, 8'hff, 8'h00}, {1'b1, ADDR_RST, 8'h00, 8'h00},
        {1'b1, 8'h20, 8'h77, 8'h00}};

    cgrd_host i_cgrd_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr),
        .o_addr(addr), .o_wdata(wdata));

    // short hold counts keep the run brief
    cgrd_top #(.OVERLOAD_FLAG_CYC(20), .SLOW_CYC(20)) i_cgrd_top (
        .i_clk(clk), .i_rstn(rstn), .i_wr(wr), .i_addr(addr),
        .i_wdata(wdata), .o_rdata(rdata), .i_fill_high(fill),
        .i_abs_mode(absm), .i_indicator_en(en), .i_pd_pins(pd),
        .i_pu_pins(pu), .i_prog_full(prog), .i_meas(meas), .o_seg(seg),
        .o_fast_eff(fast_eff), .o_eod_sample(eod),
        .o_unreliable_full_flag(unrel), .o_battery_replaced_flag(repl),
        .o_valid_discharge_flag(vdis));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // a hung wait ends the run as a failure
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_cgrd_host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic do_reset();
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // valid charge events spaced two cycles apart
    task automatic pulse_vc(input int n);
        repeat (n) begin
            @(negedge clk);
            meas.valid_charge = 1'b1;
            @(negedge clk);
            meas.valid_charge = 1'b0;
        end
    endtask

    // segments must stay dark for the whole stretch
    task automatic seg_dark();
        repeat (40) begin
            @(negedge clk);
            chk({2'h0, seg}, 8'h00);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        rstn = 1'b0;
        fill = 1'b0;
        absm = 1'b1;
        prog = 8'hc8;
        pd = 6'h09;
        pu = 6'h24;
        en = CGRD_EN_ON;
        meas = '0;
        num_errors = 0;
        num_checks = 0;
        cyc = 0;
        do_reset();
        rchk(ADDR_ACH, 8'h00);
        rchk(ADDR_LFC, 8'hc8);
        chk({5'h0, unrel, repl, vdis}, 8'h06);
        for (int i = 0; i < 11; i++) begin
            if (rows[i][24])
                i_cgrd_host.wr(rows[i][23:16], rows[i][15:8]);
            rchk(rows[i][23:16], rows[i][7:0]);
        end
        pulse_vc(3);
        rchk(ADDR_TALLY, 8'h03);
        @(negedge clk) meas.charge_up = 1'b1;
        @(negedge clk) meas.charge_up = 1'b0;
        rchk(ADDR_SF, 8'h80);
        chk({7'h0, fast_eff}, 8'h01);
        repeat (60) @(negedge clk);
        rchk(ADDR_SF, 8'h00);
        chk({7'h0, fast_eff}, 8'h00);
        // near-full charge counts only the first event
        i_cgrd_host.wr(ADDR_ACH, 8'h33);
        pulse_vc(2);
        rchk(ADDR_TALLY, 8'h04);
        rchk(ADDR_ACL, 8'h00);
        i_cgrd_host.wr(ADDR_ACH, 8'h10);
        pulse_vc(1);
        rchk(ADDR_TALLY, 8'h05);
        pulse_vc(255);
        rchk(ADDR_TALLY, 8'hff);
        // overload with heavy discharge, then the hold-off
        meas.heavy_dis = 1'b1;
        meas.overload = 1'b1;
        repeat (3) @(negedge clk);
        rchk(ADDR_SF, 8'h11);
        chk({7'h0, eod}, 8'h00);
        meas.overload = 1'b0;
        meas.heavy_dis = 1'b0;
        repeat (10) @(negedge clk);
        chk({7'h0, eod}, 8'h00);
        rchk(ADDR_SF, 8'h01);
        repeat (30) @(negedge clk);
        rchk(ADDR_SF, 8'h00);
        chk({7'h0, eod}, 8'h01);
        // full-to-empty discharge learns capacity and clears the tally
        i_cgrd_host.wr(ADDR_ACH, 8'h33);
        @(negedge clk) meas.charge_dn = 1'b1;
        @(negedge clk) meas.charge_dn = 1'b0;
        chk({5'h0, unrel, repl, vdis}, 8'h05);
        @(negedge clk) meas.first_empty = 1'b1;
        @(negedge clk) meas.first_empty = 1'b0;
        chk({5'h0, unrel, repl, vdis}, 8'h00);
        rchk(ADDR_TALLY, 8'h00);
        // unreliable flag comes back on the 64th counted charge only
        i_cgrd_host.wr(ADDR_LFC, 8'hc8);
        pulse_vc(63);
        chk({5'h0, unrel, repl, vdis}, 8'h00);
        pulse_vc(1);
        chk({5'h0, unrel, repl, vdis}, 8'h04);
        i_cgrd_host.soft_reset();
        repeat (3) @(negedge clk);
        rchk(ADDR_LFC, 8'hc8);
        rchk(ADDR_TALLY, 8'h00);
        rchk(ADDR_ACH, 8'h00);
        rchk(ADDR_PACK, 8'h5a);
        chk({5'h0, unrel, repl, vdis}, 8'h06);
        // fill strap settles before the reset that samples it
        fill = 1'b1;
        repeat (3) @(negedge clk);
        do_reset();
        rchk(ADDR_ACH, 8'hc8);
        rchk(ADDR_ACL, 8'h00);
        repeat (4) @(negedge clk);
        chk({2'h0, seg}, 8'h15);
        // relative mode scales to the learned capacity instead
        i_cgrd_host.wr(ADDR_LFC, 8'hff);
        absm = 1'b0;
        repeat (4) @(negedge clk);
        chk({2'h0, seg}, 8'h05);
        en = CGRD_EN_FLOAT;
        repeat (4) @(negedge clk);
        chk({2'h0, seg}, 8'h00);
        meas.fast_count = 1'b1;
        repeat (4) @(negedge clk);
        chk({2'h0, seg}, 8'h05);
        en = CGRD_EN_OFF;
        repeat (4) @(negedge clk);
        seg_dark();
        en = CGRD_EN_ON;
        meas.final_empty = 1'b1;
        repeat (4) @(negedge clk);
        seg_dark();
        end_sim();
    end
endmodule
